// ### grsp_pkg.sv
// Shared types and constants of the rate sensor command/response port.
// Assumes one core clock domain and one serial clock domain beside it.
package grsp_pkg;

  // ---------------------------------------------------------------
  // Frame layout
  // ---------------------------------------------------------------
  localparam int          FRAME_BITS   = 32;
  localparam int          CNT_W        = 6;
  localparam logic [5:0]  CNT_FULL     = 6'h20;
  localparam logic [31:0] INIT_WORD    = 32'h0000_0001;

  // Command field positions
  localparam int CMD_SENSOR_BIT = 29;
  localparam int CMD_CHECK_BIT  = 1;
  localparam int CMD_IDX_HI     = 25;
  localparam int CMD_IDX_LO     = 17;
  localparam int CMD_DATA_HI    = 16;
  localparam int CMD_DATA_LO    = 1;
  localparam int CMD_MSEL_HI    = 28;
  localparam int CMD_MSEL_LO    = 26;

  // Response constant fields
  localparam logic [2:0] HDR_READ   = 3'h2;
  localparam logic [2:0] HDR_WRITE  = 3'h1;
  localparam logic [2:0] HDR_ERROR  = 3'h0;
  localparam logic [3:0] RW_MARK    = 4'he;

  // Response kind codes
  localparam logic [1:0] KIND_INVALID  = 2'h0;
  localparam logic [1:0] KIND_VALID    = 2'h1;
  localparam logic [1:0] KIND_SELFTEST = 2'h2;
  localparam logic [1:0] KIND_RW       = 2'h3;

  // Minimum chip select high gap and its length in core cycles
  localparam real CORE_PERIOD_NS = 10.0;
  localparam real GAP_MIN_US     = 0.1;
  localparam int  GAP_MIN_CYC    = (int'($ceil(GAP_MIN_US * 1000.0 / CORE_PERIOD_NS)) < 1) ? 1 :
                                   int'($ceil(GAP_MIN_US * 1000.0 / CORE_PERIOD_NS));

  // Live sensor state caught at frame start
  typedef struct packed {
    logic [15:0] rate;
    logic [6:0]  fault;
    logic [1:0]  kind;
  } grsp_snap_t;

  // Register write request toward the register map
  typedef struct packed {
    logic [2:0]  module_select;
    logic [8:0]  register_index;
    logic [15:0] payload_word;
  } grsp_wreq_t;

endpackage

// ### grsp_top.sv
// Serial command/response port of an angular rate sensor, mode 0 slave.
// Assumes the master gives 32 clocks per frame and the register map answers
// a read in the cycle after the index is presented.
//
// Overview of operation
// - Fixed 32-bit frames; each answer goes out during the next frame.
// - Clock idles low, input sampled on rising edge, output changed on falling edge.
// - First frame after reset shifts out 0x00000001.
// - Chip select active low; commands on master-out, answers on master-in.
// - Sensor command: bit 29 set, tag at 31/30/28, check at 1, parity 0.
// - Read/write: bit 29 clear, module 28:26, index 25:17, write data 16:1.
// - Sensor answer: tag, first parity, kind, rate 25:10, faults 7:1, parity.
// - Read answers start 010, writes 001, then 1110, module, data 20:5.
// - Error answer starts 000, zeros at 20:19, flags at 18/17/16, faults.
// - Chip select falling takes a snapshot of the live sensor state.
// - Chip select rising after a full command builds the next answer.
// - Frames may follow each other with only 0.1 us of gap.
// - Answer data is as old as the master's frame spacing.
// - First parity makes 31:16 odd, final parity makes the whole word odd.
// - Kind reads 00 invalid, 01 valid, 10 self-test, 11 read/write.
// - Sensor tag bits are echoed unchanged into the answer.
`timescale 1ns/10ps
module grsp_top
  import grsp_pkg::*;
(
  input  wire logic              CORE_CLK_I,
  input  wire logic              RST_N_I,
  input  wire logic              SCLK_I,
  input  wire logic              CS_N_I,
  input  wire logic              MOSI_I,
  output logic                   MISO_O,
  output logic                   MISO_OE_O,
  input  wire grsp_pkg::grsp_snap_t SENSOR_I,
  output logic [8:0]             REG_INDEX_O,
  input  wire logic [15:0]       REG_RDATA_I,
  input  wire logic              REG_LEGAL_I,
  input  wire logic              REG_WRITABLE_I,
  output logic                   REG_WR_O,
  output grsp_pkg::grsp_wreq_t   REG_WREQ_O
);
  import grsp_pkg::*;

  // ---------------------------------------------------------------
  // Serial clock domain
  // ---------------------------------------------------------------
  logic [31:0] rx_q;
  logic [5:0]  cnt_q;
  logic [31:0] word_q;
  logic        done_tgl_q;
  logic        long_tgl_q;
  logic [4:0]  ocnt_q;
  logic [31:0] tx_q;

  // Input shifter, cleared by chip select high since no clock runs then
  always_ff @(posedge SCLK_I or posedge CS_N_I) begin
    if (CS_N_I) begin
      rx_q  <= '0;
      cnt_q <= '0;
    end else begin
      rx_q  <= {rx_q[30:0], MOSI_I};
      // Stops one past full, so an overlong frame toggles the long flag only once
      cnt_q <= (cnt_q == CNT_FULL + 6'h01) ? cnt_q : cnt_q + 6'h01;
    end
  end

  // Whole command and frame events, handed over by toggles
  always_ff @(posedge SCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      word_q     <= '0;
      done_tgl_q <= 1'b0;
      long_tgl_q <= 1'b0;
    end else begin
      if (cnt_q == CNT_FULL - 6'h01) begin
        word_q     <= {rx_q[30:0], MOSI_I};
        done_tgl_q <= ~done_tgl_q;
      end
      if (cnt_q == CNT_FULL - 6'h01 + 6'h01) begin
        long_tgl_q <= ~long_tgl_q;
      end
    end
  end

  // Output bit pointer advances on the falling edge
  always_ff @(negedge SCLK_I or posedge CS_N_I) begin
    if (CS_N_I) begin
      ocnt_q <= '0;
    end else begin
      ocnt_q <= ocnt_q + 5'h01;
    end
  end

  // tx_q is only rewritten while chip select is high, so it is quiet here
  assign MISO_O    = ~CS_N_I & tx_q[5'd31 - ocnt_q];
  assign MISO_OE_O = ~CS_N_I;

  // ---------------------------------------------------------------
  // Crossings into the core clock
  // ---------------------------------------------------------------
  logic [2:0] sy1_q;
  logic [2:0] sy2_q;
  logic       cs_prev_q;
  logic       done_seen_q;
  logic       long_seen_q;

  // Two stages each for chip select and the two toggles.
  // word_q is read only after its toggle has crossed, and it holds until
  // the 32nd rising edge of the next frame, so it needs no stages of its own.
  always_ff @(posedge CORE_CLK_I) begin
    sy1_q <= {CS_N_I, done_tgl_q, long_tgl_q};
    sy2_q <= sy1_q;
  end

  wire cs_s    = sy2_q[2];
  wire done_s  = sy2_q[1];
  wire long_s  = sy2_q[0];
  // Edges of synced chip select; prev resets high like an idle pin, so no false edge
  wire cs_fall = cs_prev_q & ~cs_s;
  wire cs_rise = ~cs_prev_q & cs_s;

  // ---------------------------------------------------------------
  // Command decode
  // ---------------------------------------------------------------
  wire        cmd_sensor   = word_q[CMD_SENSOR_BIT];
  wire [2:0]  cmd_tag      = {word_q[28], word_q[31], word_q[30]};
  wire        cmd_check    = word_q[CMD_CHECK_BIT];
  wire [2:0]  cmd_msel     = word_q[CMD_MSEL_HI:CMD_MSEL_LO];
  wire [8:0]  cmd_index    = word_q[CMD_IDX_HI:CMD_IDX_LO];
  wire [15:0] cmd_data     = word_q[CMD_DATA_HI:CMD_DATA_LO];
  wire        cmd_parity   = ^word_q;
  // Reads carry no payload, so any set bit in 16:1 marks a write
  wire        cmd_write    = ~cmd_sensor & (cmd_data != 16'h0000);

  // ---------------------------------------------------------------
  // Core state
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {ST_IDLE, ST_FETCH, ST_BUILD} grsp_state_t;

  grsp_state_t st_q;
  grsp_snap_t  snap_q;
  logic        frame_err_q;
  logic        illegal_q;
  logic        stale_q;
  logic [31:0] resp_w;
  logic [31:0] body_w;

  // Snapshot at frame start keeps the answer fixed while sensors move
  always_ff @(posedge CORE_CLK_I) begin
    if (!RST_N_I) begin
      snap_q <= '0;
    end else if (cs_fall) begin
      snap_q <= SENSOR_I;
    end
  end

  // Frame bookkeeping; seen copies take the live toggles at reset
  always_ff @(posedge CORE_CLK_I) begin
    if (!RST_N_I) begin
      cs_prev_q   <= 1'b1;
      done_seen_q <= done_s;
      long_seen_q <= long_s;
      st_q        <= ST_IDLE;
      frame_err_q <= 1'b0;
      illegal_q   <= 1'b0;
      stale_q     <= 1'b0;
    end else begin
      cs_prev_q <= cs_s;
      unique case (st_q)
        ST_IDLE: begin
          if (cs_rise) begin
            done_seen_q <= done_s;
            long_seen_q <= long_s;
            frame_err_q <= (done_s == done_seen_q) | (long_s != long_seen_q);
            st_q        <= ST_FETCH;
          end
        end
        ST_FETCH: begin
          illegal_q <= ~cmd_sensor & (~REG_LEGAL_I | (cmd_write & ~REG_WRITABLE_I));
          st_q      <= ST_BUILD;
        end
        ST_BUILD: begin
          st_q <= ST_IDLE;
        end
      endcase
      // A new frame opening before the answer is ready reads old data
      if (cs_fall && st_q != ST_IDLE) begin
        stale_q <= 1'b1;
      end else if (st_q == ST_BUILD) begin
        stale_q <= 1'b0;
      end
    end
  end

  // Any flagged condition turns the whole answer into an error answer
  wire any_err = frame_err_q | illegal_q | ~cmd_parity | stale_q;

  // ---------------------------------------------------------------
  // Answer composition, parity bits filled last
  // ---------------------------------------------------------------
  always_comb begin
    body_w = '0;
    if (any_err) begin
      body_w = {HDR_ERROR, 1'b0, RW_MARK, cmd_msel, 2'b00,
                frame_err_q | ~cmd_parity, illegal_q, stale_q,
                8'h00, snap_q.fault, 1'b0};
    end else if (cmd_sensor) begin
      body_w = {cmd_tag, 1'b0, snap_q.kind, snap_q.rate, 2'b00,
                snap_q.fault[6:1], snap_q.fault[0] | cmd_check, 1'b0};
    end else begin
      body_w = {cmd_write ? HDR_WRITE : HDR_READ, 1'b0, RW_MARK, cmd_msel,
                cmd_write ? cmd_data : REG_RDATA_I, 5'h00};
    end
    resp_w     = body_w;
    resp_w[28] = ~^{body_w[31:29], body_w[27:16]};
    resp_w[0]  = ~^resp_w[31:1];
  end

  // Answer word, loaded only between frames
  always_ff @(posedge CORE_CLK_I) begin
    if (!RST_N_I) begin
      tx_q <= INIT_WORD;
    end else if (st_q == ST_BUILD) begin
      tx_q <= resp_w;
    end
  end

  // Register map requests, write issued only for a clean command
  assign REG_INDEX_O = cmd_index;
  always_ff @(posedge CORE_CLK_I) begin
    if (!RST_N_I) begin
      REG_WR_O   <= 1'b0;
      REG_WREQ_O <= '0;
    end else begin
      REG_WR_O   <= (st_q == ST_BUILD) & ~any_err & cmd_write;
      REG_WREQ_O <= '{module_select: cmd_msel, register_index: cmd_index, payload_word: cmd_data};
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (!RST_N_I);

  init_word_a: assert property ($rose(RST_N_I) |-> tx_q == INIT_WORD)
    else $error("answer after reset is not the start word");
  full_parity_a: assert property (^tx_q == 1'b1)
    else $error("answer word parity is not odd");
  upper_parity_a: assert property (tx_q != INIT_WORD |-> ^tx_q[31:16] == 1'b1)
    else $error("upper half parity is not odd");
  snap_take_a: assert property (cs_fall |=> snap_q == $past(SENSOR_I))
    else $error("snapshot missed at frame start");
  build_load_a: assert property (cs_rise && st_q == ST_IDLE |-> ##2 st_q == ST_BUILD ##1 tx_q == $past(resp_w))
    else $error("answer not loaded after frame end");
  rw_header_a: assert property (st_q == ST_BUILD && !any_err && !cmd_sensor
                                |=> tx_q[27:24] == RW_MARK && tx_q[31:29] != HDR_ERROR)
    else $error("read or write answer header wrong");
  err_header_a: assert property (st_q == ST_BUILD && any_err
                                 |=> tx_q[31:29] == HDR_ERROR && tx_q[20:19] == 2'b00)
    else $error("error answer header wrong");
  tag_echo_a: assert property (st_q == ST_BUILD && !any_err && cmd_sensor
                               |=> tx_q[31:29] == $past(cmd_tag) && tx_q[27:26] == $past(snap_q.kind))
    else $error("sensor answer tag or kind wrong");
  frame_hold_a: assert property (!cs_s && !$past(cs_s) |-> $stable(tx_q))
    else $error("answer changed during a frame");

  // Answer word and snapshot move only at their own events
  load_time_a: assert property (!$stable(tx_q) |-> $past(st_q) == ST_BUILD)
    else $error("answer changed outside a build");
  snap_hold_a: assert property (!cs_fall |=> $stable(snap_q))
    else $error("snapshot changed inside a frame");

  // Wrong clock count or bad parity comes back as a framing error, an illegal command as the illegal flag
  count_flag_a: assert property (cs_rise && st_q == ST_IDLE && done_s == done_seen_q |=> frame_err_q)
    else $error("short frame not flagged");
  frame_flag_a: assert property (st_q == ST_BUILD && (frame_err_q || !cmd_parity)
                                 |=> tx_q[31:29] == HDR_ERROR && tx_q[18])
    else $error("framing flag missing from answer");
  illegal_flag_a: assert property (st_q == ST_BUILD && illegal_q
                                   |=> tx_q[31:29] == HDR_ERROR && tx_q[17])
    else $error("illegal command flag missing");

  // Sensor answers carry the rate and faults caught at frame start; answers to read/write commands carry kind 11
  rate_copy_a: assert property (st_q == ST_BUILD && !any_err && cmd_sensor
                                |=> tx_q[25:10] == $past(snap_q.rate) && tx_q[7:2] == $past(snap_q.fault[6:1]))
    else $error("sensor answer rate or faults wrong");
  rw_kind_a: assert property (st_q == ST_BUILD && !cmd_sensor |=> tx_q[27:26] == KIND_RW)
    else $error("read or write answer kind wrong");

  // Write strobe is one cycle long and matches the write answer just loaded
  wr_pulse_a: assert property (REG_WR_O |=> !REG_WR_O)
    else $error("write strobe longer than one cycle");
  wr_echo_a: assert property (REG_WR_O |-> tx_q[31:29] == HDR_WRITE
                              && REG_WREQ_O.payload_word == tx_q[20:5]
                              && REG_WREQ_O.module_select == tx_q[23:21])
    else $error("write request differs from its answer");

endmodule

// ### grsp_master.sv
// Serial master model for the rate sensor port, mode 0, 32 ns clock period.
// Assumes the bench calls xfer once at a time; clock stands still outside frames.
`timescale 1ns/10ps
module grsp_master (
  output logic      sclk_o,
  output logic      cs_n_o,
  output logic      mosi_o,
  input  wire logic miso_i
);
  // Idle: clock low, deselected
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    mosi_o = 1'b0;
  end

  // One framed exchange; n other than 32 or bad parity only when a test asks
  task automatic xfer(input logic [31:0] cmd, input int n, input bit bad, input int gap,
                      output logic [31:0] rsp);
    logic [31:0] c;
    c = cmd;
    c[0] = bad ? ^cmd[31:1] : ~^cmd[31:1];
    rsp = '0;
    #3.3;
    cs_n_o = 1'b0;
    mosi_o = c[31];
    #16;
    for (int i = 0; i < n; i++) begin
      if (i < 32) rsp = {rsp[30:0], miso_i};
      sclk_o = 1'b1;
      #16;
      sclk_o = 1'b0;
      mosi_o = (i < 31) ? c[30 - i] : ~mosi_o;
      #16;
    end
    cs_n_o = 1'b1;
    mosi_o = ~mosi_o; // Released line must not look like held data
    #(gap);
  endtask
endmodule

// ### grsp_top_tb_top.sv
// Self-checking bench of the rate sensor serial port.
// Assumes grsp_pkg, grsp_top and grsp_master are compiled before it.
`timescale 1ns/10ps
module grsp_top_tb_top;
  import grsp_pkg::*;
  logic        clk, rst_n, sclk, cs_n, mosi, miso, miso_oe, wr;
  logic [8:0]  idx;
  grsp_snap_t  snap;
  grsp_wreq_t  wreq, wr_last;
  logic [31:0] exp_w;
  int          num_errors, num_checks, wr_cnt, cyc;

  // ---------------------------------------------------------------
  // Design, master model and register map stub
  // ---------------------------------------------------------------
  grsp_top uut (
    .CORE_CLK_I     (clk),
    .RST_N_I        (rst_n),
    .SCLK_I         (sclk),
    .CS_N_I         (cs_n),
    .MOSI_I         (mosi),
    .MISO_O         (miso),
    .MISO_OE_O      (miso_oe),
    .SENSOR_I       (snap),
    .REG_INDEX_O    (idx),
    .REG_RDATA_I    ({7'h2b, idx}),
    .REG_LEGAL_I    (idx != 9'h1ff),
    .REG_WRITABLE_I (~idx[8]),
    .REG_WR_O       (wr),
    .REG_WREQ_O     (wreq)
  );
  grsp_master m (.sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi), .miso_i(miso));

  // Core clock; the master's edges sit off its grid on purpose
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Write strobes seen by the register map, and hang guard
  always @(posedge clk) begin
    cyc++;
    if (wr === 1'b1) begin
      wr_cnt++;
      wr_last = wreq;
    end
    if (cyc == 5000) begin
      num_errors++;
      $display("ERROR %0t timeout", $time);
      summarize();
    end
  end

  // Output driven only while selected
  always @(negedge clk) begin
    if (rst_n && (miso_oe !== ~cs_n || (cs_n && miso !== 1'b0))) begin
      num_errors++;
      $display("ERROR %0t output enable or idle level", $time);
    end
  end

  // ---------------------------------------------------------------
  // Frame builders; first parity bit starts at 0 so one xnor sets it
  // ---------------------------------------------------------------
  function automatic logic [31:0] par(logic [31:0] w);
    w[28] = ~^w[31:16];
    w[0] = ~^w[31:1];
    return w;
  endfunction
  function automatic logic [31:0] sens(logic [2:0] t, logic c);
    return {t[1], t[0], 1'b1, t[2], 26'h0, c, 1'b0};
  endfunction
  function automatic logic [31:0] rw(logic [2:0] ms, logic [8:0] ix, logic [15:0] d);
    return {3'h0, ms, ix, d, 1'b0};
  endfunction
  function automatic logic [31:0] sens_rsp(logic [31:0] c, grsp_snap_t s);
    return par({c[28], c[31], c[30], 1'b0, s.kind, s.rate, 2'h0, s.fault[6:1], s.fault[0] | c[1], 1'b0});
  endfunction
  function automatic logic [31:0] rw_rsp(logic [2:0] h, logic [2:0] ms, logic [15:0] d);
    return par({h, 1'b0, RW_MARK, ms, d, 5'h0});
  endfunction
  function automatic logic [31:0] err_rsp(logic frm, logic ill);
    return par({HDR_ERROR, 1'b0, RW_MARK, 3'h0, 2'h0, frm, ill, 1'b0, 8'h0, 7'h0, 1'b0});
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // One frame: answer judged against the previous command; the live state is
  // spoiled mid-frame so only the snapshot at frame start may show up
  task automatic run(input logic [31:0] c, input int n, input bit bad, input int gap,
                     input grsp_snap_t s, input logic [31:0] nxt);
    logic [31:0] rsp;
    @(negedge clk);
    snap <= s;
    fork
      m.xfer(c, n, bad, gap, rsp);
      begin
        #300;
        @(negedge clk);
        snap <= {16'hdead, 7'h7f, 2'h0};
      end
    join
    // A short frame shifts out only the leading bits of the answer
    chk(rsp, (n >= 32) ? exp_w : exp_w >> (32 - n), "frame answer");
    exp_w = nxt;
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_first;
    grsp_snap_t s;
    s = {16'h7ffe, 7'h01, KIND_VALID};
    exp_w = INIT_WORD;
    run(sens(3'h6, 1'b1), 32, 1'b0, 200, s, sens_rsp(sens(3'h6, 1'b1), s));
  endtask

  task automatic t_sensor;
    grsp_snap_t s;
    for (int k = 0; k < 4; k++) begin
      s = {16'h8001 + 16'(k * 16'h1111), 7'(7'h41 >> k), 2'(k)};
      run(sens(3'(k + 3), k[0]), 32, 1'b0, 110, s, sens_rsp(sens(3'(k + 3), k[0]), s));
    end
  endtask

  task automatic t_regs;
    grsp_snap_t s;
    s = '0;
    run(rw(3'h0, 9'h023, 16'h0), 32, 1'b0, 200, s, rw_rsp(HDR_READ, 3'h0, 16'h5623));
    run(rw(3'h5, 9'h044, 16'hbeef), 32, 1'b0, 200, s, rw_rsp(HDR_WRITE, 3'h5, 16'hbeef));
    chk({4'h0, wr_last}, {4'h0, 3'h5, 9'h044, 16'hbeef}, "write request");
    run(rw(3'h0, 9'h150, 16'h0001), 32, 1'b0, 200, s, err_rsp(1'b0, 1'b1));
    run(rw(3'h0, 9'h1ff, 16'h0), 32, 1'b0, 200, s, err_rsp(1'b0, 1'b1));
    chk(32'(wr_cnt), 32'd1, "write count");
  endtask

  task automatic t_framing;
    grsp_snap_t s;
    s = '0;
    run(rw(3'h0, 9'h0, 16'h0), 33, 1'b0, 200, s, err_rsp(1'b1, 1'b0));
    run(rw(3'h0, 9'h0, 16'h0), 34, 1'b0, 200, s, err_rsp(1'b1, 1'b0));
    run(rw(3'h0, 9'h0, 16'h0), 31, 1'b0, 200, s, err_rsp(1'b1, 1'b0));
    run(rw(3'h0, 9'h0, 16'h0), 32, 1'b1, 200, s, err_rsp(1'b1, 1'b0));
    run(sens(3'h1, 1'b0), 32, 1'b0, 200, s, sens_rsp(sens(3'h1, 1'b0), s));
    run(sens(3'h2, 1'b1), 32, 1'b0, 200, s, 32'h0);
  endtask

  task automatic summarize;
    if (num_errors == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // Reset, then the scenarios in order
  initial begin
    rst_n = 1'b0;
    snap = '0;
    exp_w = '0;
    repeat (12) @(negedge clk);
    rst_n <= 1'b1;
    repeat (6) @(negedge clk);
    t_first();
    t_sensor();
    t_regs();
    t_framing();
    summarize();
  end
endmodule
